// ==== hdl/instrument_digital_io.sv ====
/*
  Digital input/output port: eight polarity-configurable action inputs and
  eight polarity-configurable state outputs. Input pins are asynchronous;
  configuration and instrument state come from logic on clk_sys.
*/
module instrument_digital_io
  import dio_pkg::*;
(
  input  wire logic                  clk_sys,
  input  wire logic                  sys_rst,
  input  wire logic [NUM_IN-1:0]     input_line_n_pin,
  input  wire logic [2*NUM_IN-1:0]   in_action,
  input  wire logic [NUM_IN-1:0]     in_active_high,
  input  wire logic [5*NUM_OUT-1:0]  out_select,
  input  wire logic [NUM_OUT-1:0]    out_active_high,
  input  wire logic [NUM_FAULTS-1:0] fault_flags,
  input  wire logic                  usb_disconnected,
  input  wire logic                  phase_background,
  input  wire logic                  phase_span,
  input  wire logic                  phase_zero,
  input  wire logic                  system_fault,
  output logic [1:0]                 cal_select,
  output logic                       cal_request,
  output logic [NUM_OUT-1:0]         output_line
);

  typedef struct packed {
    logic [NUM_IN-1:0]  sync1;
    logic [NUM_IN-1:0]  sync2;
    logic [NUM_IN-1:0]  act_prev;
    cal_sel_t           cal;
    logic               req;
    logic [NUM_OUT-1:0] out;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  logic [NUM_IN-1:0]  in_act;
  logic [NUM_IN-1:0]  rise;
  logic [NUM_OUT-1:0] state_true;
  logic               any_rise;

  assign any_rise = |rise;

  genvar g;
  generate
    for (g = 0; g < NUM_IN; g++) begin : g_in
      assign in_act[g] = in_active_high[g] ? st_r.sync2[g] : ~st_r.sync2[g];
      assign rise[g]   = in_act[g] & ~st_r.act_prev[g]
                         & (in_action[2*g +: 2] != ACT_DISABLED);
    end
    for (g = 0; g < NUM_OUT; g++) begin : g_out
      logic [4:0] sel;
      assign sel = out_select[5*g +: 5];
      always_comb begin
        state_true[g] = 1'b0;
        if (sel >= SEL_FAULT_LO && sel < SEL_USB_DISC) begin
          state_true[g] = fault_flags[4'(sel - SEL_FAULT_LO)];
        end else if (sel == SEL_USB_DISC) begin
          state_true[g] = usb_disconnected;
        end else if (sel == SEL_BACKGND) begin
          state_true[g] = phase_background;
        end else if (sel == SEL_SPAN) begin
          state_true[g] = phase_span;
        end else if (sel == SEL_ZERO) begin
          state_true[g] = phase_zero;
        end else if (sel == SEL_SYS_FAULT) begin
          state_true[g] = system_fault;
        end else begin
          state_true[g] = 1'b0;
        end
      end
    end
  endgenerate

  always_comb begin
    st_nxt          = st_r;
    st_nxt.sync1    = input_line_n_pin;
    st_nxt.sync2    = st_r.sync1;
    st_nxt.act_prev = in_act;
    st_nxt.req      = 1'b0;
    // Lowest numbered span or zero line wins when several fire together
    for (int i = NUM_IN - 1; i >= 0; i--) begin
      if (rise[i]) begin
        if (in_action[2*i +: 2] == ACT_SPAN) begin
          st_nxt.cal = CAL_SPAN;
          st_nxt.req = 1'b1;
        end else if (in_action[2*i +: 2] == ACT_ZERO) begin
          st_nxt.cal = CAL_ZERO;
          st_nxt.req = 1'b1;
        end
      end
    end
    // Polarity applied to the selected state
    st_nxt.out = ~(state_true ^ out_active_high);
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_r          <= '0;
      // Synchronisers start at the inactive level, no false edge
      st_r.sync1    <= ~in_active_high;
      st_r.sync2    <= ~in_active_high;
      st_r.cal      <= CAL_RESET;
      st_r.out      <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cal_select  = st_r.cal;
  assign cal_request = st_r.req;
  assign output_line = st_r.out;

  generate
    if (NUM_IN != 8 || NUM_OUT != 8) begin : g_bad_count
      $error("Unsupported line count");
    end
  endgenerate

  a_span_request: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (rise[0] && in_action[1:0] == ACT_SPAN) |=> (cal_select == CAL_SPAN && cal_request))
    else $error("Span request not taken");
  a_zero_request: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (rise[0] && in_action[1:0] == ACT_ZERO) |=> (cal_select == CAL_ZERO && cal_request))
    else $error("Zero request not taken");
  a_disabled_quiet: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (in_action == '0) |=> !cal_request)
    else $error("Disabled inputs raised a request");
  a_single_launch: assert property (@(posedge clk_sys) disable iff (sys_rst)
    cal_request |=> !cal_request)
    else $error("Action launched twice");
  a_sync_delay: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (in_active_high[0] && in_action[1:0] == ACT_SPAN && !in_act[0] && !st_r.sync1[0] && input_line_n_pin[0]
     && $stable(in_active_high[0]) && $stable(in_action[1:0])) ##1 input_line_n_pin[0]
     |=> ##1 cal_request)
    else $error("Active-high input not launched after sync");
  a_output_follow: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (out_select[4:0] == SEL_SYS_FAULT) |=> (output_line[0] == ~($past(system_fault) ^ $past(out_active_high[0]))))
    else $error("Output does not follow state");
  a_disabled_out: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (out_select[4:0] == SEL_DISABLED) |=> (output_line[0] == ~$past(out_active_high[0])))
    else $error("Disabled output went active");
  a_fault_flag: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (out_select[4:0] == 5'h04 && out_active_high[0]) |=> (output_line[0] == $past(fault_flags[3])))
    else $error("Converter fault not routed");

  // Input side checks
  a_low_line_wins: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (rise[0] && rise[1] && in_action[1:0] == ACT_SPAN && in_action[3:2] == ACT_ZERO)
    |=> (cal_select == CAL_SPAN && cal_request))
    else $error("Lower line did not win");
  a_top_line: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (rise[7] && rise[6:0] == 7'h00 && in_action[15:14] == ACT_ZERO)
    |=> (cal_select == CAL_ZERO && cal_request))
    else $error("Line seven request lost");
  a_code3_quiet: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (in_action == 16'hFFFF)
    |=> !cal_request)
    else $error("Reserved action raised a request");
  a_reserved_action: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (rise[0] && in_action[1:0] == 2'h3 && rise[7:1] == 7'h00)
    |=> !cal_request)
    else $error("Reserved action on line zero launched");
  a_request_cause: assert property (@(posedge clk_sys) disable iff (sys_rst)
    cal_request
    |-> $past(any_rise))
    else $error("Request without an input edge");
  a_request_code: assert property (@(posedge clk_sys) disable iff (sys_rst)
    cal_request
    |-> (cal_select == CAL_SPAN || cal_select == CAL_ZERO))
    else $error("Request with no calibration selection");
  a_select_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !cal_request
    |-> $stable(cal_select))
    else $error("Calibration selection moved without request");
  a_active_low_in: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!in_active_high[1] && in_action[3:2] == ACT_ZERO && !st_r.sync2[1] && !st_r.act_prev[1] && !rise[0])
    |=> (cal_request && cal_select == CAL_ZERO))
    else $error("Active-low input not launched");
  a_reset_values: assert property (@(posedge clk_sys)
    sys_rst
    |=> (!cal_request && cal_select == CAL_NONE && output_line == 8'h00))
    else $error("Reset values wrong");

  // Output side checks
  a_usb_route: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (out_select[9:5] == SEL_USB_DISC)
    |=> (output_line[1] == ~($past(usb_disconnected) ^ $past(out_active_high[1]))))
    else $error("Storage disconnect not routed");
  a_fault_first: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (out_select[4:0] == SEL_FAULT_LO)
    |=> (output_line[0] == ~($past(fault_flags[0]) ^ $past(out_active_high[0]))))
    else $error("First fault flag not routed");
  a_fault_last: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (out_select[4:0] == 5'h0C)
    |=> (output_line[0] == ~($past(fault_flags[11]) ^ $past(out_active_high[0]))))
    else $error("Last fault flag not routed");
  a_background_route: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (out_select[9:5] == SEL_BACKGND)
    |=> (output_line[1] == ~($past(phase_background) ^ $past(out_active_high[1]))))
    else $error("Background phase not routed");
  a_span_phase: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (out_select[4:0] == SEL_SPAN)
    |=> (output_line[0] == ~($past(phase_span) ^ $past(out_active_high[0]))))
    else $error("Span phase not routed");
  a_zero_phase: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (out_select[9:5] == SEL_ZERO)
    |=> (output_line[1] == ~($past(phase_zero) ^ $past(out_active_high[1]))))
    else $error("Zero phase not routed");
  a_sysfault_second: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (out_select[9:5] == SEL_SYS_FAULT)
    |=> (output_line[1] == ~($past(system_fault) ^ $past(out_active_high[1]))))
    else $error("System fault not routed");
  a_unused_code: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (out_select[4:0] > SEL_SYS_FAULT)
    |=> (output_line[0] == ~$past(out_active_high[0])))
    else $error("Unused selection went active");

  for (g = 0; g < NUM_OUT; g++) begin : g_out_chk
    a_out_disabled: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (out_select[5*g +: 5] == SEL_DISABLED)
      |=> (output_line[g] == ~$past(out_active_high[g])))
      else $error("Disabled output line went active");
  end

  c_span_launch: cover property (@(posedge clk_sys) cal_request && cal_select == CAL_SPAN);
  c_zero_launch: cover property (@(posedge clk_sys) cal_request && cal_select == CAL_ZERO);
  c_out_active_low: cover property (@(posedge clk_sys) !out_active_high[0] && !output_line[0]);
  c_low_line_race: cover property (@(posedge clk_sys) rise[0] && rise[1]);
  c_out_fault_active: cover property (@(posedge clk_sys) out_select[4:0] == SEL_FAULT_LO && fault_flags[0]);

endmodule

// ==== hdl/dio_pkg.sv ====
/*
  Constants and encodings for the instrument digital input/output port.
  Assumes a single 10 MHz system clock and a synchronous active-high reset.
*/
package dio_pkg;
  localparam int NUM_IN  = 8;
  localparam int NUM_OUT = 8;

  typedef enum logic [1:0] {
    ACT_DISABLED = 2'h0,
    ACT_SPAN     = 2'h1,
    ACT_ZERO     = 2'h2
  } in_action_t;

  typedef enum logic [1:0] {
    CAL_NONE = 2'h0,
    CAL_SPAN = 2'h1,
    CAL_ZERO = 2'h2
  } cal_sel_t;

  // Output state selection codes; fault flag bit i maps to code i+1
  localparam logic [4:0] SEL_DISABLED  = 5'h00;
  localparam logic [4:0] SEL_FAULT_LO  = 5'h01;
  localparam int         NUM_FAULTS    = 12;
  localparam logic [4:0] SEL_USB_DISC  = 5'h0D;
  localparam logic [4:0] SEL_BACKGND   = 5'h0E;
  localparam logic [4:0] SEL_SPAN      = 5'h0F;
  localparam logic [4:0] SEL_ZERO      = 5'h10;
  localparam logic [4:0] SEL_SYS_FAULT = 5'h11;

  localparam cal_sel_t CAL_RESET = CAL_NONE;
  localparam logic     SYNC_RESET = 1'b0;
endpackage

// ==== sim/dio_partner.sv ====
/*
  Far-side logger or calibrator model driving the eight input lines.
  Assumes clk_sys, line requests and line polarity come from the bench.
*/
module dio_partner (
  input  wire logic       clk_sys,
  input  wire logic [7:0] req,
  input  wire logic [7:0] pol,
  output logic      [7:0] pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // Requested line goes to its active level
  always_ff @(posedge clk_sys) pin <= ~(req ^ pol);
endmodule

// ==== sim/testbench.sv ====
/*
  Self-checking bench for instrument_digital_io.
  Assumes dio_pkg and dio_partner are compiled first.
*/
module testbench
  import dio_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  req = 8'h00;
  logic [7:0]  in_pol = 8'hFD;
  logic [15:0] in_action = 16'h0009;
  logic [39:0] out_select = 40'h0;
  logic [7:0]  out_pol = 8'h01;
  logic [16:0] src = 17'h0;
  logic [7:0]  pin, output_line;
  logic [1:0]  cal_select;
  logic        cal_request;
  int          errors = 0;
  int          samples_checked = 0;

  always #50 clk_sys = ~clk_sys;

  dio_partner partner (.clk_sys(clk_sys), .req(req), .pol(in_pol), .pin(pin));

  instrument_digital_io dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .input_line_n_pin(pin), .in_action(in_action),
    .in_active_high(in_pol), .out_select(out_select), .out_active_high(out_pol),
    .fault_flags(src[11:0]), .usb_disconnected(src[12]), .phase_background(src[13]),
    .phase_span(src[14]), .phase_zero(src[15]), .system_fault(src[16]),
    .cal_select(cal_select), .cal_request(cal_request), .output_line(output_line)
  );

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic wait_req(input cal_sel_t exp_sel);
    int n = 0;
    while (cal_request !== 1'b1 && n < 8) begin
      @(posedge clk_sys);
      #1 n++;
    end
    check("cal_request", {7'h0, cal_request}, 8'h01);
    check("cal_select", {6'h0, cal_select}, {6'h0, exp_sel});
    @(posedge clk_sys);
    #1 check("cal_pulse", {7'h0, cal_request}, 8'h00);
  endtask

  task automatic quiet(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      #1 check("no_request", {7'h0, cal_request}, 8'h00);
    end
  endtask

  // Span on active-high line 0, held without retrigger
  task automatic t_span();
    @(posedge clk_sys);
    req <= 8'h01;
    wait_req(CAL_SPAN);
    quiet(6);
  endtask

  // Release line 0, zero on active-low line 1
  task automatic t_zero();
    @(posedge clk_sys);
    req <= 8'h02;
    wait_req(CAL_ZERO);
  endtask

  // Line 2 disabled, then reserved code, toggles with no effect
  task automatic t_dis();
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_sys);
      in_action <= (k == 0) ? 16'h0009 : 16'h0039;
      req       <= 8'h04;
      quiet(6);
      @(posedge clk_sys);
      req <= 8'h00;
      quiet(4);
    end
    check("cal_hold", {6'h0, cal_select}, {6'h0, CAL_ZERO});
  endtask

  // Every state code on both polarities, outputs 2 to 7 disabled
  task automatic t_out();
    for (int s = 1; s <= 17; s++) begin
      @(posedge clk_sys);
      out_select <= {30'h0, 5'(s), 5'(s)};
      src <= 17'h0;
      @(posedge clk_sys);
      src <= 17'h1 << (s - 1);
      #1 check("out_idle", output_line, 8'hFE);
      @(posedge clk_sys);
      #1 check("out_active", output_line, 8'hFD);
    end
  endtask

  initial begin
    #100us;
    errors++;
    test_done();
  end

  initial begin
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    quiet(3);
    t_span();
    t_zero();
    t_dis();
    t_out();
    test_done();
  end
endmodule
